// *** logic/cimpd_debounce.sv ***
// Per-source debounce filter with bypass
`timescale 1ns/1ps
`include "cimpd_defs.svh"

module cimpd_debounce #(
  parameter int CYCLES = `CIMPD_DB_CYCLES,
  parameter int CNT_W = $clog2(CYCLES + 1)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic din,
  output logic dout
);
  import cimpd_pkg::*;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic out_r;
  logic out_nxt;

  // Filter: output moves only after the input has differed for CYCLES cycles
  always_comb begin
    cnt_nxt = '0;
    out_nxt = out_r;
    if (!enable) begin
      out_nxt = din;
    end else if (din != out_r) begin
      if (cnt_r == LAST) begin
        out_nxt = din;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  // Counter and output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign dout = out_r;

  // Bypassed filter follows its input one cycle later
  chk_db_bypass_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> dout == $past(din))
    else $error("debounce bypass did not follow input");

  // A change held too briefly is not passed
  chk_db_short_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (enable && din != dout && cnt_r != LAST) |=> $stable(dout))
    else $error("debounce passed a change too early");

  // A change held long enough is passed at the last count
  chk_db_settle_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (enable && din != dout && cnt_r == LAST) |=> dout == $past(din))
    else $error("debounce did not pass a settled change");

endmodule

// *** logic/cimpd_defs.svh ***
// Register indices, field positions, reset values and counts of the interrupt conditioner
`ifndef CIMPD_DEFS_SVH
`define CIMPD_DEFS_SVH

// Number of interrupt sources
`define CIMPD_NSRC 10

// Register indices; the byte address is four times the index
`define CIMPD_IDX_STATUS 10'h07F
`define CIMPD_IDX_MASK 10'h080
`define CIMPD_IDX_POL 10'h081
`define CIMPD_IDX_DB 10'h082

// Reset values of the per-source fields
`define CIMPD_MASK_RST 10'h3FF
`define CIMPD_POL_RST 10'h000
`define CIMPD_DB_RST 10'h000
`define CIMPD_FLAG_RST 10'h000

// Bit positions within the status, mask, polarity and debounce words
`define CIMPD_BIT_SUMMARY 10
`define CIMPD_BIT_PIN4 9
`define CIMPD_BIT_SEQ 8
`define CIMPD_BIT_LOCK 2
`define CIMPD_BIT_SHORT 1
`define CIMPD_BIT_DETECT 0

// Cycles a changed condition must hold before the filter passes it
`define CIMPD_DB_CYCLES 16

`endif

// *** logic/cimpd_pkg.sv ***
// Types shared by the interrupt conditioner modules
package cimpd_pkg;

  // Raw source conditions, bit 9 down to bit 0
  typedef struct packed {
    logic pin4;
    logic sequencer_busy;
    logic pin3;
    logic pin2;
    logic pin1;
    logic input8;
    logic input7;
    logic loop_locked;
    logic bias_short;
    logic bias_detect;
  } cimpd_src_t;

  // Register bus slave states, one-hot
  typedef enum logic [1:0] {
    CIMPD_ST_IDLE = 2'h1,
    CIMPD_ST_ACK = 2'h2
  } cimpd_bus_st_t;

endpackage

// *** logic/cimpd_top.sv ***
// Interrupt mask, polarity and debounce conditioner with APB register slave
// Behaviour
// - Ten mask bits 9..0 block their source when 1 and all reset to 1.
// - Bits 9..0 are pin4, sequencer, pin3, pin2, pin1, input8, input7, lock, short, detect.
// - Each source has a polarity bit, reset 0, where 0 flags a high and 1 a low condition.
// - Sequencer polarity 0 flags while busy and 1 flags while idle.
// - Lock polarity 0 flags when lock is reached and 1 flags while not locked.
// - Each source has a debounce enable, reset 0, that filters its condition when 1.
// - The two bias monitor debounce enables act independently of each other and all others.
// - Status bit 10 reads as the OR of all ten source flags.
// - A set flag stays set until software writes 1 to its bit; writing 0 leaves it alone.
`timescale 1ns/1ps
`include "cimpd_defs.svh"

module cimpd_top #(
  parameter int NSRC = `CIMPD_NSRC,
  parameter int DEBOUNCE_CYCLES = `CIMPD_DB_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cimpd_pkg::cimpd_src_t sources,
  output logic irq
);
  import cimpd_pkg::*;

  // Bus slave state
  cimpd_bus_st_t state_r;
  cimpd_bus_st_t state_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // Decode
  logic [9:0] idx;
  logic hit_status;
  logic hit_mask;
  logic hit_pol;
  logic hit_db;
  logic addr_ok;
  logic accept;
  logic wr_en;
  logic [NSRC-1:0] wmask;
  logic [NSRC-1:0] wbits;

  // Configuration registers
  logic [NSRC-1:0] interrupt_source_mask_r;
  logic [NSRC-1:0] interrupt_source_mask_nxt;
  logic [NSRC-1:0] interrupt_source_polarity_r;
  logic [NSRC-1:0] interrupt_source_polarity_nxt;
  logic [NSRC-1:0] interrupt_source_debounce_r;
  logic [NSRC-1:0] interrupt_source_debounce_nxt;

  // Source path and flags
  logic [NSRC-1:0] raw_vec;
  logic [NSRC-1:0] cond_vec;
  logic [NSRC-1:0] event_vec;
  logic [NSRC-1:0] flags_r;
  logic [NSRC-1:0] flags_nxt;
  logic [NSRC-1:0] clr_vec;
  logic [NSRC-1:0] keep_vec;
  logic any_flag;
  logic irq_r;
  logic irq_nxt;

  // Helper for the mask reset check only
  logic mask_wr_seen_r;

  // Address decode; misaligned or unknown addresses answer with an error
  always_comb begin
    idx = paddr[11:2];
    hit_status = (idx == `CIMPD_IDX_STATUS);
    hit_mask = (idx == `CIMPD_IDX_MASK);
    hit_pol = (idx == `CIMPD_IDX_POL);
    hit_db = (idx == `CIMPD_IDX_DB);
    addr_ok = (paddr[1:0] == 2'h0) && (hit_status || hit_mask || hit_pol || hit_db);
  end

  // Write takes effect only at the edge where the master sees pready
  always_comb begin
    accept = (state_r == CIMPD_ST_ACK) && psel && penable;
    wr_en = accept && pwrite && addr_ok;
    wmask = {{2{pstrb[1]}}, {8{pstrb[0]}}};
    wbits = pwdata[NSRC-1:0] & wmask;
  end

  // Bus state machine; one wait state keeps every bus output registered
  always_comb begin
    state_nxt = state_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    case (state_r)
      CIMPD_ST_IDLE: begin
        if (psel && penable) begin
          state_nxt = CIMPD_ST_ACK;
          pready_nxt = 1'b1;
          pslverr_nxt = !addr_ok;
          prdata_nxt = 32'h0000_0000;
          if (!pwrite && addr_ok) begin
            if (hit_status) begin
              prdata_nxt = {21'h00_0000, any_flag, flags_r};
            end else if (hit_mask) begin
              prdata_nxt = {22'h00_0000, interrupt_source_mask_r};
            end else if (hit_pol) begin
              prdata_nxt = {22'h00_0000, interrupt_source_polarity_r};
            end else begin
              prdata_nxt = {22'h00_0000, interrupt_source_debounce_r};
            end
          end
        end
      end
      CIMPD_ST_ACK: begin
        state_nxt = CIMPD_ST_IDLE;
      end
      default: begin
        state_nxt = CIMPD_ST_IDLE;
      end
    endcase
  end

  // Bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CIMPD_ST_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Mask, polarity and debounce words, byte lanes honoured
  always_comb begin
    interrupt_source_mask_nxt = interrupt_source_mask_r;
    interrupt_source_polarity_nxt = interrupt_source_polarity_r;
    interrupt_source_debounce_nxt = interrupt_source_debounce_r;
    if (wr_en && hit_mask) begin
      interrupt_source_mask_nxt = (interrupt_source_mask_r & ~wmask) | wbits;
    end
    if (wr_en && hit_pol) begin
      interrupt_source_polarity_nxt = (interrupt_source_polarity_r & ~wmask) | wbits;
    end
    if (wr_en && hit_db) begin
      interrupt_source_debounce_nxt = (interrupt_source_debounce_r & ~wmask) | wbits;
    end
  end

  // Configuration registers; sources start blocked, active high, unfiltered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_source_mask_r <= `CIMPD_MASK_RST;
      interrupt_source_polarity_r <= `CIMPD_POL_RST;
      interrupt_source_debounce_r <= `CIMPD_DB_RST;
      mask_wr_seen_r <= 1'b0;
    end else begin
      interrupt_source_mask_r <= interrupt_source_mask_nxt;
      interrupt_source_polarity_r <= interrupt_source_polarity_nxt;
      interrupt_source_debounce_r <= interrupt_source_debounce_nxt;
      mask_wr_seen_r <= mask_wr_seen_r | (wr_en && hit_mask);
    end
  end

  // Struct packs pin4 at bit 9 down to bias detect at bit 0
  assign raw_vec = sources;

  // Polarity before the filter, so the filter sees the active condition
  always_comb begin
    cond_vec = raw_vec ^ interrupt_source_polarity_r;
  end

  // One filter per source with its own enable and counter
  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_src
      cimpd_debounce #(
        .CYCLES(DEBOUNCE_CYCLES)
      ) u_db (
        .pclk(pclk),
        .presetn(presetn),
        .enable(interrupt_source_debounce_r[i]),
        .din(cond_vec[i]),
        .dout(event_vec[i])
      );
    end
  endgenerate

  // Sticky flags; a set in the clearing cycle wins over the clear
  always_comb begin
    clr_vec = (wr_en && hit_status) ? wbits : '0;
    keep_vec = flags_r & ~clr_vec;
    flags_nxt = keep_vec | event_vec;
    any_flag = |flags_r;
  end

  // Masked sources are recorded but kept off the line
  always_comb begin
    irq_nxt = |(flags_r & ~interrupt_source_mask_r);
  end

  // Flag and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= `CIMPD_FLAG_RST;
      irq_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  // Mask word stays all ones until software writes it
  chk_mask_reset_ones: assert property (@(posedge pclk) disable iff (!presetn)
    !mask_wr_seen_r |-> interrupt_source_mask_r == `CIMPD_MASK_RST)
    else $error("mask word left its reset value without a write");

  // Pin4 condition lands in bit 9 unfiltered
  chk_field_order_pin4: assert property (@(posedge pclk) disable iff (!presetn)
    (!interrupt_source_debounce_r[`CIMPD_BIT_PIN4] && !interrupt_source_polarity_r[`CIMPD_BIT_PIN4]
     && sources.pin4) |=> event_vec[`CIMPD_BIT_PIN4])
    else $error("pin4 condition did not reach bit 9");

  // Active condition sets its flag on the following edge
  chk_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (flags_r & $past(event_vec)) == $past(event_vec))
    else $error("active condition did not set its flag");

  // Sequencer idle with polarity 1 flags two edges later
  chk_seq_idle_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_source_polarity_r[`CIMPD_BIT_SEQ] && !interrupt_source_debounce_r[`CIMPD_BIT_SEQ]
     && !sources.sequencer_busy) |-> ##2 flags_r[`CIMPD_BIT_SEQ])
    else $error("idle sequencer with inverted polarity did not flag");

  // Loop lock with polarity 0 flags two edges later
  chk_lock_reached_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (!interrupt_source_polarity_r[`CIMPD_BIT_LOCK] && !interrupt_source_debounce_r[`CIMPD_BIT_LOCK]
     && sources.loop_locked) |-> ##2 flags_r[`CIMPD_BIT_LOCK])
    else $error("reached lock did not flag");

  // Detect path follows one cycle later while only the short path filters
  chk_bias_independent: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_source_debounce_r[`CIMPD_BIT_SHORT] && !interrupt_source_debounce_r[`CIMPD_BIT_DETECT])
    |=> event_vec[`CIMPD_BIT_DETECT] == $past(cond_vec[`CIMPD_BIT_DETECT]))
    else $error("detect path was held by the short path filter");

  // Status read returns the summary of all flags in bit 10
  chk_summary_read: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == CIMPD_ST_IDLE && psel && penable && !pwrite && addr_ok && hit_status)
    |=> prdata_r[`CIMPD_BIT_SUMMARY] == $past(any_flag))
    else $error("summary bit differs from the OR of the flags");

  // Flags not cleared by a one stay set
  chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (flags_r & $past(keep_vec)) == $past(keep_vec))
    else $error("flag dropped without a write of one");

  // Nothing unmasked pending keeps the line low
  chk_mask_blocks_irq: assert property (@(posedge pclk) disable iff (!presetn)
    ((flags_r & ~interrupt_source_mask_r) == '0) |=> !irq_r)
    else $error("interrupt raised with only masked flags");

  // An unmasked pending flag raises the line
  chk_unmasked_raises: assert property (@(posedge pclk) disable iff (!presetn)
    ((flags_r & ~interrupt_source_mask_r) != '0) |=> irq_r)
    else $error("unmasked flag did not raise the interrupt");

  // Access phase is answered after exactly one wait state
  chk_bus_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
    else $error("access phase not answered after one wait state");

  // A one written while no source is active clears that flag
  chk_flag_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_status && event_vec == '0) |=> (flags_r & $past(clr_vec)) == '0)
    else $error("flag survived a write of one");

  // Unknown or misaligned access is answered with an error
  chk_bad_addr_error: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == CIMPD_ST_IDLE && psel && penable && !addr_ok) |=> pready_r && pslverr_r)
    else $error("bad address not answered with an error");

endmodule

// *** tb/cimpd_host.sv ***
// Host model counting requests raised on the combined interrupt line
`timescale 1ns/1ps

module cimpd_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq,
  output logic [15:0] irq_events
);
  logic irq_r;

  // Counts rising edges only, so a request left standing is serviced once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      irq_events <= 16'h0000;
    end else begin
      irq_r <= irq;
      if (irq && !irq_r) begin
        irq_events <= irq_events + 16'h0001;
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt mask, polarity and debounce conditioner
`timescale 1ns/1ps
`include "cimpd_defs.svh"

module testbench;
  import cimpd_pkg::*;
  // Short filter keeps the run brief
  localparam int DB = 4;
  localparam logic [11:0] A_ST = {`CIMPD_IDX_STATUS, 2'h0};
  localparam logic [11:0] A_MK = {`CIMPD_IDX_MASK, 2'h0};
  localparam logic [11:0] A_PL = {`CIMPD_IDX_POL, 2'h0};
  localparam logic [11:0] A_DB = {`CIMPD_IDX_DB, 2'h0};

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cimpd_src_t src = cimpd_src_t'(10'h000);
  logic irq;
  logic [15:0] irq_events;
  logic [32:0] exp_q[$];
  int error_cnt = 0;
  int tests_run = 0;

  always #4 pclk = ~pclk;

  cimpd_top #(.DEBOUNCE_CYCLES(DB)) u_cimpd_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sources(src), .irq(irq)
  );

  cimpd_host u_cimpd_host (
    .pclk(pclk), .presetn(presetn), .irq(irq), .irq_events(irq_events)
  );

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // One APB transfer; a read leaves its expected answer in the queue
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [32:0] e);
    int n;
    @(posedge pclk);
    if (!wr) exp_q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hF, {1'b0, e});
  endtask

  task automatic drive(input logic [9:0] v);
    @(posedge pclk);
    src <= cimpd_src_t'(v);
  endtask

  // Monitor: every read answer is matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) cmp(33'h1_FFFF_FFFF, {pslverr, prdata});
      else cmp(exp_q.pop_front(), {pslverr, prdata});
    end
  end

  initial begin
    logic [9:0] v;
    int i;
    v = 10'($urandom(32'h2BF9));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then refused accesses
    rd(A_ST, 32'h0);
    rd(A_MK, 32'h3FF);
    rd(A_PL, 32'h0);
    rd(A_DB, 32'h0);
    apb(1'b0, A_DB + 12'h004, 32'h0, 4'hF, {1'b1, 32'h0});
    apb(1'b0, A_MK + 12'h001, 32'h0, 4'hF, {1'b1, 32'h0});
    // Random mask patterns read back whole
    repeat (3) begin
      v = 10'($urandom);
      wr(A_MK, {22'h0, v});
      rd(A_MK, {22'h0, v});
    end
    // Low lane strobe only: bits 9..8 must survive
    wr(A_MK, 32'h3FF);
    apb(1'b1, A_MK, 32'h0, 4'h1, 33'h0);
    rd(A_MK, 32'h300);
    wr(A_MK, 32'h3FF);
    // Each source alone; read only after the source went idle
    for (i = 0; i < 10; i++) begin
      drive(10'h001 << i);
      repeat (3) @(posedge pclk);
      drive(10'h000);
      repeat (3) @(posedge pclk);
      rd(A_ST, 32'h400 | (32'h1 << i));
      cmp(33'h0, {32'h0, irq});
      wr(A_ST, 32'h0);
      rd(A_ST, 32'h400 | (32'h1 << i));
      wr(A_ST, 32'h1 << i);
      rd(A_ST, 32'h0);
    end
    // Named fields must land on their own bits, not just on a numeric position
    @(posedge pclk);
    src <= '{sequencer_busy: 1'b1, loop_locked: 1'b1, default: 1'b0};
    drive(10'h000);
    repeat (3) @(posedge pclk);
    rd(A_ST, 32'h504);
    wr(A_ST, 32'h104);
    rd(A_ST, 32'h0);
    // Flag recorded while masked reaches the line once unmasked
    drive(10'h020);
    repeat (3) @(posedge pclk);
    drive(10'h000);
    wr(A_MK, 32'h3DF);
    repeat (2) @(posedge pclk);
    cmp(33'h1, {32'h0, irq});
    wr(A_ST, 32'h20);
    repeat (2) @(posedge pclk);
    cmp(33'h0, {32'h0, irq});
    cmp(33'h1, {17'h0, irq_events});
    wr(A_MK, 32'h3FF);
    // Active low on all sources; sequencer idle and loop unlocked flag
    wr(A_PL, 32'h3FF);
    repeat (3) @(posedge pclk);
    rd(A_ST, 32'h7FF);
    drive(10'h2FF);
    repeat (3) @(posedge pclk);
    wr(A_ST, 32'h3FF);
    rd(A_ST, 32'h500);
    wr(A_PL, 32'h0);
    drive(10'h000);
    repeat (3) @(posedge pclk);
    wr(A_ST, 32'h3FF);
    rd(A_ST, 32'h0);
    // Filter on the short monitor only; a two cycle glitch on both
    wr(A_DB, 32'h2);
    rd(A_DB, 32'h2);
    drive(10'h003);
    @(posedge pclk);
    drive(10'h000);
    repeat (DB + 3) @(posedge pclk);
    rd(A_ST, 32'h401);
    drive(10'h002);
    repeat (DB + 4) @(posedge pclk);
    drive(10'h000);
    repeat (DB + 4) @(posedge pclk);
    rd(A_ST, 32'h403);
    wr(A_ST, 32'h3);
    rd(A_ST, 32'h0);
    repeat (2) @(posedge pclk);
    tally_and_finish();
  end
endmodule
